// ===== hdl/sd3_top.sv
// sinc3 decimator top: modulator tick, rate counter, settling, apb registers
`timescale 1ns/1ps
`default_nettype none
module sd3_top
    import sd3_pkg::*;
#(
    parameter int P_CLK_HZ = CLK_HZ,
    parameter int P_MOD_HZ = MOD_HZ
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_mod_bit,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [31:0] o_result,
    output logic o_result_valid,
    output logic [CHAN_W-1:0] o_channel,
    output logic o_settling
);
    generate
        if (P_MOD_HZ <= 0 || 2 * P_MOD_HZ > P_CLK_HZ || P_CLK_HZ >= (1 << PHASE_W))
        begin : g_bad_rate
            $error("sd3_top: clock must be at least twice the modulator rate");
        end
    endgenerate

    localparam logic [PHASE_W-1:0] PH_ADD = PHASE_W'(P_MOD_HZ);
    localparam logic [PHASE_W-1:0] PH_WRAP = PHASE_W'(P_CLK_HZ);

    // ratio is eight times the stored factor
    function automatic logic [CNT_W-1:0] period_ticks(input logic [DECIM_W-1:0] f);
        period_ticks = CNT_W'(f) * CNT_W'(DECIM_MULT);
    endfunction

    sd3_if cbus ();

    sd3_core sd3_core_i (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .bus(cbus)
    );

    logic sync1_q;
    logic sync2_q;
    logic [PHASE_W-1:0] phase_q, phase_d;
    logic tick_q, tick_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [DECIM_W-1:0] decim_q, decim_d;
    logic chop_off_q, chop_off_d;
    logic [CHAN_W-1:0] chan_q, chan_d;
    logic ready_q, ready_d;
    logic [31:0] data_q, data_d;
    logic [1:0] skip_q, skip_d;
    sd3_state_t state_q, state_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    logic [31:0] result_q, result_d;
    logic res_vld_d;
    logic restart;
    logic running;
    logic setup;
    logic done_wr;
    logic done_rd;
    logic mapped;
    logic [DECIM_W-1:0] wr_decim;

    // ---------------------------------------------------------------
    // modulator bit synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= i_mod_bit;
            sync2_q <= sync1_q;
        end
    end

    // ---------------------------------------------------------------
    // next values
    // ---------------------------------------------------------------
    always_comb
    begin
        setup = i_psel && !i_penable;
        mapped = (i_paddr == ADDR_DECIM) || (i_paddr == ADDR_CTRL) ||
                 (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_DATA);
        done_wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
        done_rd = i_psel && i_penable && o_pready && !i_pwrite && !o_pslverr;
        // values below the minimum are raised to it
        wr_decim = (i_pwdata[DECIM_W-1:0] < DECIM_MIN) ? DECIM_MIN : i_pwdata[DECIM_W-1:0];
        decim_d = decim_q;
        chop_off_d = chop_off_q;
        chan_d = chan_q;
        restart = 1'b0;
        if (done_wr && i_paddr == ADDR_DECIM)
        begin
            // only the eight factor bits set the rate
            decim_d = wr_decim;
            restart = 1'b1;
        end
        if (done_wr && i_paddr == ADDR_CTRL)
        begin
            chop_off_d = i_pwdata[CTRL_CHOP_OFF_BIT];
            chan_d = i_pwdata[CTRL_CHAN_LSB +: CHAN_W];
            // a new channel restarts like a synchronized step
            restart = (i_pwdata[CTRL_CHAN_LSB +: CHAN_W] != chan_q) ||
                      (i_pwdata[CTRL_CHOP_OFF_BIT] != chop_off_q);
        end
        // unchopped path runs only with the chop-off bit set
        running = chop_off_q && !restart;

        // fractional divider: average tick rate is exact, jitter one clock
        tick_d = 1'b0;
        phase_d = phase_q + PH_ADD;
        if (phase_d >= PH_WRAP)
        begin
            phase_d = phase_d - PH_WRAP;
            tick_d = 1'b1;
        end

        cbus.mod_en = tick_q && running;
        cbus.mod_bit = sync2_q;
        cbus.clear = restart || !chop_off_q;
        cbus.dec_en = 1'b0;
        cnt_d = cnt_q;
        if (cbus.clear)
        begin
            cnt_d = '0;
        end
        else if (cbus.mod_en)
        begin
            // one result per 8*factor modulator ticks
            // each factor step adds eight ticks, 0.244 ms
            if (cnt_q >= period_ticks(decim_q) - CNT_W'(1))
            begin
                cnt_d = '0;
                cbus.dec_en = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + CNT_W'(1);
            end
        end

        state_d = state_q;
        skip_d = skip_q;
        res_vld_d = 1'b0;
        result_d = result_q;
        data_d = data_q;
        ready_d = ready_q;
        if (done_rd && i_paddr == ADDR_DATA)
        begin
            ready_d = 1'b0;
        end
        case (state_q)
            SD3_ST_STOP:
            begin
                if (chop_off_q && !restart)
                begin
                    state_d = SD3_ST_SETTLE;
                    skip_d = 2'(SETTLE_CONV - 1);
                end
            end
            SD3_ST_SETTLE:
            begin
                // first two results after a restart are held back
                if (cbus.result_en)
                begin
                    if (skip_q == 2'd0)
                    begin
                        state_d = SD3_ST_RUN;
                    end
                    else
                    begin
                        skip_d = skip_q - 2'd1;
                    end
                end
            end
            SD3_ST_RUN:
            begin
                state_d = SD3_ST_RUN;
            end
            default:
            begin
                state_d = SD3_ST_STOP;
            end
        endcase
        if (restart || !chop_off_q)
        begin
            state_d = SD3_ST_STOP;
        end
        // results keep flowing through unsynchronized steps
        // settling ends on the very edge of the first delivered result
        if (cbus.result_en && state_d == SD3_ST_RUN)
        begin
            result_d = cbus.result[ACC_W-1:1];
            data_d = cbus.result[ACC_W-1:1];
            res_vld_d = 1'b1;
            // new result wins over a clearing read
            ready_d = 1'b1;
        end

        // registered slave answer: ready in every access phase
        pready_d = setup;
        pslverr_d = setup && !mapped;
        prdata_d = '0;
        if (setup && !i_pwrite)
        begin
            case (i_paddr)
                ADDR_DECIM: prdata_d = {24'h0000_00, decim_q};
                ADDR_CTRL: prdata_d = 32'(chan_q) << CTRL_CHAN_LSB | 32'(chop_off_q);
                ADDR_STATUS: prdata_d = 32'(o_settling) << STATUS_SETTLING_BIT | 32'(ready_q) << STATUS_READY_BIT;
                ADDR_DATA: prdata_d = data_q;
                default: prdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            phase_q <= '0;
            tick_q <= 1'b0;
            cnt_q <= '0;
            decim_q <= DECIM_RST;
            chop_off_q <= CTRL_CHOP_OFF_RST;
            chan_q <= '0;
            ready_q <= 1'b0;
            data_q <= '0;
            skip_q <= '0;
            state_q <= SD3_ST_STOP;
            result_q <= '0;
            o_result_valid <= 1'b0;
            o_settling <= 1'b1;
            o_prdata <= '0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            decim_q <= decim_d;
            chop_off_q <= chop_off_d;
            chan_q <= chan_d;
            ready_q <= ready_d;
            data_q <= data_d;
            skip_q <= skip_d;
            state_q <= state_d;
            result_q <= result_d;
            o_result_valid <= res_vld_d;
            o_settling <= (state_d != SD3_ST_RUN);
            o_prdata <= prdata_d;
            o_pready <= pready_d;
            o_pslverr <= pslverr_d;
        end
    end

    assign o_result = result_q;
    assign o_channel = chan_q;
endmodule
`default_nettype wire

// ===== pkg/sd3_pkg.sv
// constants and types of the sinc3 decimator, chop off
package sd3_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MOD_HZ = 32_768;
    localparam int PHASE_W = 24;
    localparam int DECIM_W = 8;
    localparam int DECIM_MULT = 8;
    localparam int CNT_W = 11;
    localparam int ACC_W = 33;
    localparam int CHAN_W = 4;
    localparam int SETTLE_CONV = 3;
    localparam int UNSYNC_CONV = 4;
    localparam logic [DECIM_W-1:0] DECIM_MIN = 8'h03;
    localparam logic [DECIM_W-1:0] DECIM_RST = 8'h45;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_DECIM = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam int CTRL_CHOP_OFF_BIT = 0;
    localparam int CTRL_CHAN_LSB = 4;
    localparam logic CTRL_CHOP_OFF_RST = 1'b1;
    localparam int STATUS_READY_BIT = 0;
    localparam int STATUS_SETTLING_BIT = 1;
    typedef enum logic [1:0] {SD3_ST_STOP, SD3_ST_SETTLE, SD3_ST_RUN} sd3_state_t;
endpackage

// ===== pkg/sd3_if.sv
// carrier between the rate controller and the sinc3 core
`timescale 1ns/1ps
`default_nettype none
interface sd3_if;
    import sd3_pkg::*;
    logic mod_en;
    logic mod_bit;
    logic dec_en;
    logic clear;
    logic [ACC_W-1:0] result;
    logic result_en;
    modport ctrl (output mod_en, output mod_bit, output dec_en, output clear, input result, input result_en);
    modport core (input mod_en, input mod_bit, input dec_en, input clear, output result, output result_en);
endinterface
`default_nettype wire

// ===== hdl/sd3_core.sv
// sinc3 integrator and differentiator chain
`timescale 1ns/1ps
`default_nettype none
module sd3_core
    import sd3_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    sd3_if.core bus
);
    logic [ACC_W-1:0] int_q [3];
    logic [ACC_W-1:0] int_d [3];
    logic [ACC_W-1:0] dly_q [3];
    logic [ACC_W-1:0] dly_d [3];
    logic [ACC_W-1:0] out_q;
    logic [ACC_W-1:0] out_d;
    logic vld_q;
    logic vld_d;
    logic [ACC_W-1:0] c1;
    logic [ACC_W-1:0] c2;
    logic [ACC_W-1:0] c3;

    // ---------------------------------------------------------------
    // next values
    // ---------------------------------------------------------------
    // wraparound arithmetic is intended: a unipolar sum never exceeds 2^ACC_W
    always_comb
    begin
        int_d = int_q;
        dly_d = dly_q;
        out_d = out_q;
        vld_d = 1'b0;
        // dec_en only comes with mod_en: difference the post-tick sum, so a cleared chain is exact after three periods
        c1 = int_q[2] + int_q[1] - dly_q[0];
        c2 = c1 - dly_q[1];
        c3 = c2 - dly_q[2];
        if (bus.clear)
        begin
            int_d = '{default: '0};
            dly_d = '{default: '0};
        end
        else
        begin
            if (bus.mod_en)
            begin
                int_d[0] = int_q[0] + {{(ACC_W-1){1'b0}}, bus.mod_bit};
                int_d[1] = int_q[1] + int_q[0];
                int_d[2] = int_q[2] + int_q[1];
            end
            if (bus.dec_en)
            begin
                dly_d[0] = int_d[2];
                dly_d[1] = c1;
                dly_d[2] = c2;
                out_d = c3;
                vld_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            int_q <= '{default: '0};
            dly_q <= '{default: '0};
            out_q <= '0;
            vld_q <= 1'b0;
        end
        else
        begin
            int_q <= int_d;
            dly_q <= dly_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    assign bus.result = out_q;
    assign bus.result_en = vld_q;
endmodule
`default_nettype wire

// ===== sim/sd3_assertions.sv
// port checker of the sinc3 decimator
`timescale 1ns/1ps
`default_nettype none
module sd3_assertions
    import sd3_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [31:0] o_result,
    input wire logic o_result_valid,
    input wire logic [CHAN_W-1:0] o_channel,
    input wire logic o_settling
);
    logic bad;
    logic wr;
    logic [CHAN_W-1:0] chan;
    assign bad = !(i_paddr inside {ADDR_DECIM, ADDR_CTRL, ADDR_STATUS, ADDR_DATA});
    assign wr = i_psel && i_penable && o_pready && i_pwrite;
    assign chan = i_pwdata[CTRL_CHAN_LSB+:CHAN_W];
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    // ----------------
    // properties
    // ----------------
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_settle_end;
        o_settling ##1 !o_settling;
    endsequence
    property p_ready;
        s_setup |=> o_pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_err;
        s_setup |=> o_pslverr == $past(bad);
    endproperty
    a_err: assert property (p_err) else $error("wrong slverr");
    property p_pulse;
        o_result_valid |=> !o_result_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("valid too long");
    property p_quiet;
        o_settling |-> !o_result_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("result while settling");
    property p_first;
        s_settle_end |-> o_result_valid;
    endproperty
    a_first: assert property (p_first) else $error("no first result");
    property p_hold;
        !o_result_valid |-> $stable(o_result);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_decim;
        wr && i_paddr == ADDR_DECIM |-> ##[1:2] o_settling;
    endproperty
    a_decim: assert property (p_decim) else $error("no restart");
    property p_chan;
        wr && i_paddr == ADDR_CTRL |=> o_channel == $past(chan);
    endproperty
    a_chan: assert property (p_chan) else $error("channel wrong");
    property p_stop;
        wr && i_paddr == ADDR_CTRL && !i_pwdata[CTRL_CHOP_OFF_BIT] |-> ##3 (o_settling && !o_result_valid)[*8];
    endproperty
    a_stop: assert property (p_stop) else $error("not stopped");
endmodule
`default_nettype wire

// ===== sim/sd3_mod_model.sv
// modulator bit stream source
`timescale 1ns/1ps
`default_nettype none
module sd3_mod_model
(
    input wire logic i_clk,
    input wire logic i_level,
    output logic o_bit
);
    initial o_bit = 1'b0;
    always @(posedge i_clk)
    begin
        o_bit <= i_level;
    end
endmodule
`default_nettype wire

// ===== sim/sd3_top_tb.sv
// self-checking bench of the sinc3 decimator
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t %h %h", $time, g, e); end end
module sd3_top_tb
    import sd3_pkg::*;
;
    logic i_clk = 0, i_rstn = 0, lvl = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_mod_bit, o_pready, o_pslverr, o_result_valid, o_settling, err;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, o_result, rd;
    logic [CHAN_W-1:0] o_channel;
    logic [32:0] q[$], e;
    int n_errors = 0, checked = 0;
    always #50 i_clk = ~i_clk;
    sd3_mod_model sd3_mod_model_i (.i_clk(i_clk), .i_level(lvl), .o_bit(i_mod_bit));
    sd3_top #(.P_MOD_HZ(1_000_000)) sd3_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_mod_bit(i_mod_bit),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_result(o_result),
        .o_result_valid(o_result_valid), .o_channel(o_channel), .o_settling(o_settling));
    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic [31:0] exp3(int f, logic l);
        longint x;
        x = 8 * f;
        return l ? 32'(x * x * x / 2) : 32'h0000_0000;
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        k = 0;
        do
        begin
            @(posedge i_clk);
            k++;
        end
        while (o_pready !== 1'b1 && k < 20);
        if (o_pready !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t no bus answer", $time);
            end_sim();
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
    endtask
    task automatic wv(output int c);
        c = 0;
        do
        begin
            @(posedge i_clk);
            c++;
        end
        while (o_result_valid !== 1'b1 && c < 30000);
        if (o_result_valid !== 1'b1)
        begin
            n_errors++;
            $display("BAD %0t no result", $time);
            end_sim();
        end
    endtask
    // scoreboard: every result must have been announced
    always @(posedge i_clk)
    begin
        if (o_result_valid === 1'b1)
        begin
            if (q.size() == 0)
            begin
                n_errors++;
                $display("BAD %0t unexpected result", $time);
            end
            else
            begin
                e = q.pop_front();
                if (!e[32])
                    `CHK(o_result, e[31:0])
            end
        end
    end
    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        int c, f;
        logic [31:0] ex;
        void'($urandom(32'hdda0));
        tick(12);
        i_rstn <= 1;
        apb(0, ADDR_DECIM, 0);
        `CHK(rd, 32'h0000_0045)
        apb(0, ADDR_CTRL, 0);
        `CHK(rd, 32'h0000_0001)
        apb(0, 8'h10, 0);
        `CHK({err, rd}, 33'h1_0000_0000)
        q.push_back({1'b0, exp3(69, 1)});
        wv(c);
        for (int i = 0; i < 3; i++)
        begin
            f = (i == 0) ? 2 : (i == 1) ? 4 : 5 + $urandom % 8;
            lvl <= 1'($urandom);
            apb(1, ADDR_DECIM, {24'($urandom), 8'(f)});
            if (f < 3)
                f = 3;
            apb(0, ADDR_DECIM, 0);
            `CHK(rd, 32'(f))
            apb(1, ADDR_CTRL, 32'(i * 16 + 17));
            tick(1);
            `CHK(o_channel, CHAN_W'(i + 1))
            ex = exp3(f, lvl);
            q.push_back({1'b0, ex});
            q.push_back({1'b0, ex});
            wv(c);
            wv(c);
            `CHK(c >= 80 * f - 1 && c <= 80 * f + 1, 1'b1)
        end
        tick(40 * f);
        ex = exp3(f, !lvl);
        lvl <= !lvl;
        repeat (3) q.push_back({1'b1, 32'h0000_0000});
        q.push_back({1'b0, ex});
        repeat (4) wv(c);
        apb(0, ADDR_STATUS, 0);
        `CHK(rd, 32'h0000_0001)
        apb(0, ADDR_DATA, 0);
        `CHK(rd, ex)
        apb(0, ADDR_STATUS, 0);
        `CHK(rd, 32'h0000_0000)
        apb(1, ADDR_CTRL, 32'h0000_0000);
        tick(300 * f);
        `CHK(o_settling, 1'b1)
        apb(0, ADDR_STATUS, 0);
        `CHK(rd, 32'h0000_0002)
        end_sim();
    end
endmodule
bind sd3_top sd3_assertions sd3_assertions_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_result(o_result), .o_result_valid(o_result_valid), .o_channel(o_channel),
    .o_settling(o_settling));
`default_nettype wire
